// ### dsic_pkg.sv
/*
  Shared constants and carrier types for the drive status and input
  control block: parameter addresses, status bit positions, reset
  values, extra fault reset codes and the jog sequencer states.
  Assumes a single 40 MHz clock domain and no system bus.
*/
package dsic_pkg;

  // Parameter addresses as seen from the fieldbus parameter channel
  localparam logic [15:0] ADDR_FR_CFG = 16'h0568;
  localparam logic [15:0] ADDR_STATUS = 16'h1b04;

  // Extra fault reset codes on the enable input
  localparam logic [15:0] FR_OFF      = 16'h0000;
  localparam logic [15:0] FR_FALL     = 16'h0001;
  localparam logic [15:0] FR_RISE     = 16'h0002;
  localparam logic [15:0] FR_CFG_RST  = 16'h0000;

  // Status word bit positions
  localparam int unsigned BIT_HALT    = 8;
  localparam int unsigned BIT_REMOTE  = 9;
  localparam int unsigned BIT_MODE10  = 10;
  localparam int unsigned BIT_LIMIT   = 11;
  localparam int unsigned BIT_MODE12  = 12;
  localparam int unsigned BIT_ERR     = 13;
  localparam int unsigned BIT_END     = 14;
  localparam int unsigned BIT_REF     = 15;

  // Reset values
  localparam logic [15:0] STATUS_RST  = 16'h4000;
  localparam logic        X_END_RST   = 1'b1;
  localparam logic        REF_OK_RST  = 1'b0;
  localparam logic [2:0]  PIN_RST     = 3'h0;
  localparam logic [2:0]  MODE_RST    = 3'h0;

  // Inputs from the rest of the drive
  typedef struct packed {
    logic [7:0] state_low;   // Operating state bits 0..7
    logic       halt;        // Halt in effect
    logic       standstill;  // Motor at rest
    logic       mode_bit10;  // Mode monitoring bit 10
    logic       mode_bit12;  // Mode monitoring bit 12
    logic [3:0] limit_src;   // Candidate internal limit conditions
    logic       error_stop;  // Error that blocks further processing
    logic       mode_start;  // Pulse: an operating mode starts
    logic [2:0] mode_id;     // Mode that starts
    logic       process_end; // Pulse: processing ended
    logic       zero_set;    // Pulse: zero point became valid
    logic       zero_clear;  // Pulse: zero point discarded
  } dsic_drive_t;

  // One parameter access from the fieldbus
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dsic_param_req_t;

  // Jog positive with enable sequencer
  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_RUN  = 2'b01,
    JOG_STOP = 2'b10
  } dsic_jog_t;

endpackage

// ### dsic_top.sv
/*
  Drive status word (upper byte) and discrete input control.
  Assumes: one 40 MHz clock, asynchronous active high reset, discrete
  pins asynchronous to the clock, drive core signals synchronous.
*/
// Function
// - Read-only 16-bit status word is provided
// - Bit 8 follows the halt state
// - Bit 9 set means fieldbus commands execute
// - Parameters stay accessible while bit 9 clear
// - Bit 11 source picked by limit meaning
// - Bit 13 only for blocking errors
// - Bit 14 clears when a mode starts
// - Bit 14 rises only at standstill
// - No bit 14 rise between chained modes
// - Bit 15 set once zero point valid
// - Zero point survives power stage disable
// - Enable rising edge enables power stage
// - Enable falling edge disables power stage
// - Extra fault reset on configured enable edge
// - New extra reset setting waits for enable
// - Fault reset input clears pending error
// - Local mode maps enable and reset inputs
// - Jog input rise enables and jogs positive
`timescale 1ns/1ps
module dsic_top (
  input  wire logic                     ref_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [2:0]               pins_i,
  input  wire logic                     local_mode_i,
  input  wire logic                     fb_enable_assigned_i,
  input  wire logic                     fb_reset_assigned_i,
  input  wire logic                     jog_assigned_i,
  input  wire logic [1:0]               internal_limit_meaning_sel_i,
  input  wire dsic_pkg::dsic_drive_t    drive_i,
  input  wire dsic_pkg::dsic_param_req_t param_i,
  output logic                          param_ack_o,
  output logic                          param_err_o,
  output logic [15:0]                   param_rdata_o,
  output logic [15:0]                   drive_state_word_o,
  output logic                          power_enable_req_o,
  output logic                          power_disable_req_o,
  output logic                          fault_reset_req_o,
  output logic                          jog_pos_start_o,
  output logic                          jog_stop_o
);

  // Three-stage pin synchronisers and filtered levels
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] filt_q, filt_d;
  logic [2:0] stable;
  logic [2:0] rise, fall;

  // Configuration: written value and value in force
  logic [15:0] fr_cfg_q;
  logic [15:0] fr_act_q;

  // Status state
  logic [15:0] status_q, status_d;
  logic        x_end_q, x_end_d;
  logic        pend_q, pend_d;
  logic        ref_q, ref_d;
  logic [2:0]  mode_q;

  // Jog sequencer
  dsic_pkg::dsic_jog_t jog_q, jog_d;

  // Event decode
  logic en_ok, fr_ok, jog_ok;
  logic en_rise, en_fall, fr_rise, jog_rise, jog_fall;
  logic jog_done, extra_fr;
  logic pwr_en_d, pwr_dis_d, fr_req_d;

  // Parameter access decode
  logic hit_cfg, hit_status, wr_ok, bad_acc;
  logic [15:0] rdata_d;

  // Every check below uses this clock and rests while in reset
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Extra fault reset decision for a given setting and edge pair
  function automatic logic fr_extra(input logic [15:0] cfg,
                                    input logic        r,
                                    input logic        f);
    fr_extra = (cfg == dsic_pkg::FR_FALL && f) ||
               (cfg == dsic_pkg::FR_RISE && r);
  endfunction

  // Pin synchronisers; only s2/s3 feed the change filter
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q   <= dsic_pkg::PIN_RST;
      s2_q   <= dsic_pkg::PIN_RST;
      s3_q   <= dsic_pkg::PIN_RST;
      filt_q <= dsic_pkg::PIN_RST;
    end else begin
      s1_q   <= pins_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // A change counts only when the last two stages agree
  assign stable = ~(s2_q ^ s3_q);
  assign filt_d = (filt_q & ~stable) | (s3_q & stable);
  assign rise   = filt_d & ~filt_q;
  assign fall   = ~filt_d & filt_q;

  // local input mapping
  // Local mode: pin 0 enable, pin 1 fault reset by default.
  // Fieldbus mode relies on the master mapping them first.
  // fieldbus mapping gate
  assign en_ok  = local_mode_i | fb_enable_assigned_i;
  assign fr_ok  = local_mode_i | fb_reset_assigned_i;
  assign jog_ok = jog_assigned_i;

  assign en_rise  = rise[0] & en_ok;
  assign en_fall  = fall[0] & en_ok;
  assign fr_rise  = rise[1] & fr_ok;
  assign jog_rise = rise[2] & jog_ok & (jog_q == dsic_pkg::JOG_IDLE);
  assign jog_fall = fall[2] & (jog_q == dsic_pkg::JOG_RUN);
  assign jog_done = (jog_q == dsic_pkg::JOG_STOP) & drive_i.standstill;

  // extra reset edge
  // Uses the setting in force before this edge is acted on
  assign extra_fr = fr_extra(fr_act_q, en_rise, en_fall);

  assign pwr_en_d  = en_rise | jog_rise;
  assign pwr_dis_d = en_fall | jog_done;
  assign fr_req_d  = fr_rise | extra_fr;
  property p_en_rise;
    en_rise |=> power_enable_req_o ##1 !power_enable_req_o;
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable");
  property p_en_fall;
    en_fall |=> power_disable_req_o;
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("disable");
  property p_extra_fall;
    en_fall & (fr_act_q == dsic_pkg::FR_FALL) |=> fault_reset_req_o;
  endproperty
  a_extra_fall: assert property (p_extra_fall) else $error("xfr");
  c_extra: cover property (extra_fr);

  // Command pulses, one cycle each, from flip-flops
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_enable_req_o  <= 1'b0;
      power_disable_req_o <= 1'b0;
      fault_reset_req_o   <= 1'b0;
      jog_pos_start_o     <= 1'b0;
      jog_stop_o          <= 1'b0;
    end else begin
      power_enable_req_o  <= pwr_en_d;
      power_disable_req_o <= pwr_dis_d;
      fault_reset_req_o   <= fr_req_d;
      jog_pos_start_o     <= jog_rise;
      jog_stop_o          <= jog_fall;
    end
  end

  // Jog sequencer next state
  always_comb begin
    jog_d = jog_q;
    case (jog_q)
      dsic_pkg::JOG_IDLE: begin
        if (jog_rise) jog_d = dsic_pkg::JOG_RUN;
      end
      dsic_pkg::JOG_RUN: begin
        if (jog_fall) jog_d = dsic_pkg::JOG_STOP;
      end
      // Wait for rest; disable is issued on leaving
      dsic_pkg::JOG_STOP: begin
        if (jog_done) jog_d = dsic_pkg::JOG_IDLE;
      end
      // Unused code falls back to idle
      default: jog_d = dsic_pkg::JOG_IDLE;
    endcase
  end

  // Jog state register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      jog_q <= dsic_pkg::JOG_IDLE;
    end else begin
      jog_q <= jog_d;
    end
  end
  property p_jog_order;
    jog_stop_o |-> !power_disable_req_o;
  endproperty
  a_jog_order: assert property (p_jog_order) else $error("jog");
  c_jog: cover property (jog_rise ##[1:40] jog_fall);

  // Parameter decode; accepted whatever bit 9 shows
  assign hit_cfg    = param_i.addr == dsic_pkg::ADDR_FR_CFG;
  assign hit_status = param_i.addr == dsic_pkg::ADDR_STATUS;
  // Codes above the rising-edge code are refused, value kept
  assign wr_ok      = param_i.req & param_i.we & hit_cfg &
                      (param_i.wdata <= dsic_pkg::FR_RISE);
  // Unmapped, status write or out of range value
  assign bad_acc    = param_i.req & ~wr_ok &
                      (param_i.we | ~(hit_cfg | hit_status));
  assign rdata_d    = hit_cfg    ? fr_cfg_q :
                      hit_status ? status_q : 16'h0000;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fr_cfg_q      <= dsic_pkg::FR_CFG_RST;
      fr_act_q      <= dsic_pkg::FR_CFG_RST;
      param_ack_o   <= 1'b0;
      param_err_o   <= 1'b0;
      param_rdata_o <= 16'h0000;
    end else begin
      if (wr_ok) fr_cfg_q <= param_i.wdata;
      if (pwr_en_d) fr_act_q <= fr_cfg_q;
      param_ack_o <= param_i.req;
      param_err_o <= bad_acc;
      // Read data holds between reads
      if (param_i.req & ~param_i.we) param_rdata_o <= rdata_d;
    end
  end
  property p_param_local;
    param_i.req & local_mode_i |=> param_ack_o;
  endproperty
  a_param_local: assert property (p_param_local) else $error("ack");
  property p_act_load;
    $changed(fr_act_q) |-> power_enable_req_o;
  endproperty
  a_act_load: assert property (p_act_load) else $error("cfg");

  // Processing end flag and zero point next values
  always_comb begin
    x_end_d = x_end_q;
    pend_d  = pend_q;
    ref_d   = ref_q;
    // End or halt interrupts processing; wait for rest
    if ((drive_i.process_end | drive_i.halt) & ~x_end_q) begin
      pend_d = 1'b1;
    end
    if (pend_q & drive_i.standstill) begin
      x_end_d = 1'b1;
      pend_d  = 1'b0;
    end
    if (drive_i.mode_start) begin
      x_end_d = 1'b0;
      pend_d  = 1'b0;
    end
    if (drive_i.zero_set) begin
      ref_d = 1'b1;
    end else if (drive_i.zero_clear) begin
      ref_d = 1'b0;
    end
  end
  property p_end_clear;
    drive_i.mode_start |=> !status_q[dsic_pkg::BIT_END];
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("x_end");
  property p_end_rise;
    $rose(status_q[dsic_pkg::BIT_END]) |-> $past(drive_i.standstill);
  endproperty
  a_end_rise: assert property (p_end_rise) else $error("rise");
  property p_ref_keep;
    ref_q & !drive_i.zero_clear |=> ref_q;
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("ref lost");
  c_chain: cover property (drive_i.process_end & drive_i.mode_start &
                           (drive_i.mode_id != mode_q));

  // Status word assembly
  always_comb begin
    status_d = {8'h00, drive_i.state_low};
    status_d[dsic_pkg::BIT_HALT]   = drive_i.halt;
    status_d[dsic_pkg::BIT_REMOTE] = ~local_mode_i;
    status_d[dsic_pkg::BIT_MODE10] = drive_i.mode_bit10;
    status_d[dsic_pkg::BIT_LIMIT]  =
      drive_i.limit_src[internal_limit_meaning_sel_i];
    status_d[dsic_pkg::BIT_MODE12] = drive_i.mode_bit12;
    status_d[dsic_pkg::BIT_ERR]    = drive_i.error_stop;
    status_d[dsic_pkg::BIT_END]    = x_end_d;
    status_d[dsic_pkg::BIT_REF]    = ref_d;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= dsic_pkg::STATUS_RST;
      x_end_q  <= dsic_pkg::X_END_RST;
      pend_q   <= 1'b0;
      ref_q    <= dsic_pkg::REF_OK_RST;
      mode_q   <= dsic_pkg::MODE_RST;
    end else begin
      status_q <= status_d;
      x_end_q  <= x_end_d;
      pend_q   <= pend_d;
      ref_q    <= ref_d;
      if (drive_i.mode_start) begin
        mode_q <= drive_i.mode_id;
      end
    end
  end

  assign drive_state_word_o = status_q;

  property p_halt_bit;
    ##1 drive_state_word_o[dsic_pkg::BIT_HALT] == $past(drive_i.halt);
  endproperty
  a_halt_bit: assert property (p_halt_bit) else $error("halt bit");
  property p_remote;
    ##1 status_q[dsic_pkg::BIT_REMOTE] != $past(local_mode_i);
  endproperty
  a_remote: assert property (p_remote) else $error("remote bit");

endmodule

// ### dsic_drive_model.sv
/*
  Behavioural model of the motor and drive core beside the block: it
  tracks jog motion and reports standstill back to the block.
  Assumes the block's jog pulses are one clock wide on ref_clk_i.
*/
`timescale 1ns/1ps
module dsic_drive_model #(
  parameter int unsigned STOP_CYC = 5  // Braking time in clocks
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic move_i,       // Motion owned by other modes
  input  wire logic jog_start_i,  // Jog start pulse from the block
  input  wire logic jog_stop_i,   // Jog stop pulse from the block
  output logic      standstill_o  // Motor at rest
);
  logic       jog_run_q;  // Jog motion in progress
  logic [7:0] brake_q;    // Clocks left until the motor stops

  // Motor keeps turning for a while after the stop, never at once,
  // so a disable issued straight after the stop would be caught
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      jog_run_q <= 1'b0;
      brake_q   <= 8'h00;
    end else if (jog_start_i) begin
      jog_run_q <= 1'b1;
    end else if (jog_stop_i) begin
      brake_q   <= 8'(STOP_CYC);
    end else if (brake_q != 8'h00) begin
      brake_q   <= brake_q - 8'h01;
      jog_run_q <= (brake_q != 8'h01);
    end
  end

  // Standstill only when no motion source is active
  assign standstill_o = !move_i && !jog_run_q;
endmodule

// ### test_drive_status_and_input_control.sv
/*
  Self-checking bench: parameter reads and writes, status bits, and
  the discrete input functions, with a drive model giving standstill.
  Assumes the block answers one clock after a parameter request.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_drive_status_and_input_control;
  logic                      clk, rst, local_m, fb_en, fb_fr, jog_as;
  logic [2:0]                pins;
  logic [1:0]                sel;
  logic                      move, still, ack, err, en, dis, fr, js, jst;
  logic [15:0]               rdata, ds, rd;
  logic                      er;
  dsic_pkg::dsic_drive_t     drv, drv_c;
  dsic_pkg::dsic_param_req_t prm;
  int                        fails, tests_run, n_en, n_dis, n_fr, n_js, n_jst;
  time                       t_jst, t_dis;

  dsic_top dsic_top_inst (.ref_clk_i(clk), .sys_rst_i(rst), .pins_i(pins),
    .local_mode_i(local_m), .fb_enable_assigned_i(fb_en),
    .fb_reset_assigned_i(fb_fr), .jog_assigned_i(jog_as),
    .internal_limit_meaning_sel_i(sel), .drive_i(drv_c), .param_i(prm),
    .param_ack_o(ack), .param_err_o(err), .param_rdata_o(rdata),
    .drive_state_word_o(ds), .power_enable_req_o(en),
    .power_disable_req_o(dis), .fault_reset_req_o(fr),
    .jog_pos_start_o(js), .jog_stop_o(jst));
  dsic_drive_model dsic_drive_model_inst (.ref_clk_i(clk), .sys_rst_i(rst),
    .move_i(move), .jog_start_i(js), .jog_stop_i(jst),
    .standstill_o(still));

  // Standstill comes from the model, the rest from the bench
  always_comb begin
    drv_c = drv;
    drv_c.standstill = still;
  end

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count command pulses; each stands for exactly one clock
  always @(posedge clk) begin
    if (en === 1'b1) n_en++;
    if (dis === 1'b1) begin n_dis++; t_dis = $time; end
    if (fr === 1'b1) n_fr++;
    if (js === 1'b1) n_js++;
    if (jst === 1'b1) begin n_jst++; t_jst = $time; end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One parameter access; the request is a single-clock pulse
  task automatic acc(input logic we, input logic [15:0] a,
                     input logic [15:0] d);
    int n;
    @(negedge clk);
    prm = '{req: 1'b1, we: we, addr: a, wdata: d};
    @(negedge clk);
    prm.req = 1'b0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge clk);
    if (n == 4) begin fails++; $display("BAD t=%0t got=0 exp=1", $time); end
    rd = rdata;
    er = err;
  endtask

  // Pulse counts since the last call, then cleared
  task automatic pulses(input int a, b, c, d, e);
    `CHK(n_en, a)
    `CHK(n_dis, b)
    `CHK(n_fr, c)
    `CHK(n_js, d)
    `CHK(n_jst, e)
    n_en = 0; n_dis = 0; n_fr = 0; n_js = 0; n_jst = 0;
  endtask

  // Pin change, then time for the three-stage filter and the command
  task automatic pin(input int i, input logic v);
    @(negedge clk);
    pins[i] = v;
    tick(8);
  endtask

  task automatic results;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred clocks the tests take
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    rst = 1'b1; local_m = 1'b1; fb_en = 1'b0; fb_fr = 1'b0; jog_as = 1'b1;
    pins = 3'h0; sel = 2'h0; move = 1'b0; drv = '0; prm = '0;
    fails = 0; tests_run = 0; n_en = 0; n_dis = 0; n_fr = 0; n_js = 0;
    n_jst = 0; t_jst = 0; t_dis = 0;
    tick(2);
    rst = 1'b0;
    tick(2);
    `CHK(ds, dsic_pkg::STATUS_RST)
    // parameter channel open in local mode
    acc(1'b0, dsic_pkg::ADDR_STATUS, 16'h0000);
    `CHK(rd, dsic_pkg::STATUS_RST)
    acc(1'b0, dsic_pkg::ADDR_FR_CFG, 16'h0000);
    `CHK(rd, dsic_pkg::FR_CFG_RST)
    for (int c = 0; c < 3; c++) begin
      acc(1'b1, dsic_pkg::ADDR_FR_CFG, 16'(c));
      acc(1'b0, dsic_pkg::ADDR_FR_CFG, 16'h0000);
      `CHK({er, rd}, {1'b0, 16'(c)})
    end
    acc(1'b1, dsic_pkg::ADDR_FR_CFG, 16'h0003);
    `CHK(er, 1'b1)
    acc(1'b1, dsic_pkg::ADDR_STATUS, 16'hffff);
    `CHK(er, 1'b1)
    acc(1'b0, 16'h0bad, 16'h0000);
    `CHK({er, rd}, {1'b1, 16'h0000})
    acc(1'b0, dsic_pkg::ADDR_FR_CFG, 16'h0000);
    `CHK(rd, dsic_pkg::FR_RISE)
    // Status bits follow their sources
    drv.halt = 1'b1;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_HALT], 1'b1)
    drv.halt = 1'b0;
    local_m = 1'b0;
    tick(2);
    `CHK({ds[dsic_pkg::BIT_HALT], ds[dsic_pkg::BIT_REMOTE]}, 2'b01)
    local_m = 1'b1;
    for (int i = 0; i < 4; i++) begin
      drv.limit_src = 4'h1 << i;
      sel = 2'(i);
      tick(2);
      `CHK(ds[dsic_pkg::BIT_LIMIT], 1'b1)
      sel = 2'(i + 1);
      tick(2);
      `CHK(ds[dsic_pkg::BIT_LIMIT], 1'b0)
    end
    drv.error_stop = 1'b1;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_ERR], 1'b1)
    drv.error_stop = 1'b0;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_ERR], 1'b0)
    // Low byte and mode bits 10 and 12 pass straight through
    drv.state_low = 8'h5a;
    drv.mode_bit10 = 1'b1;
    drv.mode_bit12 = 1'b1;
    tick(2);
    `CHK(ds, 16'h545a)
    drv = '0;
    // Process end bit: start, end while moving, standstill
    move = 1'b1; drv.mode_id = 3'h1; drv.mode_start = 1'b1;
    tick(1);
    drv.mode_start = 1'b0;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_END], 1'b0)
    drv.process_end = 1'b1;
    tick(1);
    drv.process_end = 1'b0;
    tick(3);
    `CHK(ds[dsic_pkg::BIT_END], 1'b0)
    move = 1'b0;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_END], 1'b1)
    // Chained modes: end and new start together, no rise
    move = 1'b1; drv.mode_start = 1'b1;
    tick(1);
    drv.mode_start = 1'b0;
    tick(2);
    drv.process_end = 1'b1; drv.mode_start = 1'b1; drv.mode_id = 3'h2;
    tick(1);
    drv.process_end = 1'b0; drv.mode_start = 1'b0; move = 1'b0;
    tick(3);
    `CHK(ds[dsic_pkg::BIT_END], 1'b0)
    drv.halt = 1'b1;
    tick(3);
    `CHK(ds[dsic_pkg::BIT_END], 1'b1)
    drv.halt = 1'b0; drv.zero_set = 1'b1;
    tick(1);
    drv.zero_set = 1'b0;
    tick(2);
    `CHK(ds[dsic_pkg::BIT_REF], 1'b1)
    // Enable pin with extra fault reset; new setting waits for enable
    pulses(0, 0, 0, 0, 0);
    pin(0, 1'b1); pulses(1, 0, 0, 0, 0);
    pin(0, 1'b0); pulses(0, 1, 0, 0, 0);
    `CHK(ds[dsic_pkg::BIT_REF], 1'b1)
    pin(0, 1'b1); pulses(1, 0, 1, 0, 0);
    acc(1'b1, dsic_pkg::ADDR_FR_CFG, dsic_pkg::FR_FALL);
    pin(0, 1'b0); pulses(0, 1, 0, 0, 0);
    pin(0, 1'b1); pulses(1, 0, 1, 0, 0);
    acc(1'b1, dsic_pkg::ADDR_FR_CFG, dsic_pkg::FR_OFF);
    pin(0, 1'b0); pulses(0, 1, 1, 0, 0);
    pin(0, 1'b1); pulses(1, 0, 0, 0, 0);
    pin(0, 1'b0); pulses(0, 1, 0, 0, 0);
    pin(1, 1'b1); pulses(0, 0, 1, 0, 0);
    pin(1, 1'b0); pulses(0, 0, 0, 0, 0);
    // fieldbus mode: inputs act only once assigned
    local_m = 1'b0;
    pin(0, 1'b1); pin(0, 1'b0); pin(1, 1'b1); pin(1, 1'b0);
    pulses(0, 0, 0, 0, 0);
    fb_en = 1'b1; fb_fr = 1'b1;
    pin(0, 1'b1); pulses(1, 0, 0, 0, 0);
    pin(0, 1'b0); pulses(0, 1, 0, 0, 0);
    pin(1, 1'b1); pulses(0, 0, 1, 0, 0);
    pin(1, 1'b0);
    // Jog positive with enable, stop then disable after standstill
    pin(2, 1'b1); pulses(1, 0, 0, 1, 0);
    pin(2, 1'b0);
    tick(10);
    pulses(0, 1, 0, 0, 1);
    `CHK(t_dis > t_jst + 100, 1'b1)
    // Mid-run reset: status word and setting return to reset values
    acc(1'b1, dsic_pkg::ADDR_FR_CFG, dsic_pkg::FR_RISE);
    local_m = 1'b1;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    `CHK(ds, dsic_pkg::STATUS_RST)
    acc(1'b0, dsic_pkg::ADDR_FR_CFG, 16'h0000);
    `CHK(rd, dsic_pkg::FR_CFG_RST)
    pulses(0, 0, 0, 0, 0);
    results();
  end
endmodule
